/* File: pkg/sfwd_defines.svh */
`ifndef SFWD_DEFINES_SVH
`define SFWD_DEFINES_SVH
`define LINE_BYTES 64
`define LINE_OFS_W 6
`define INT_FWD_CYCLES 1
`define FP_FWD_CYCLES 4
`define WAIT_W 3
`endif

/* File: pkg/sfwd_pkg.sv */
package sfwd_pkg;
  typedef enum logic [2:0] {
    LD_IDLE = 3'h1,
    LD_WAIT = 3'h2,
    LD_FWD  = 3'h4
  } ld_state_t;
endpackage

/* File: logic/store_entry_mem.sv */
`timescale 1ns/1ns
// ****************************************
// Store data array, registered read port
// ****************************************
module store_entry_mem #(
  parameter int DEPTH = 8,
  parameter int DW = 64,
  parameter int IW = 3
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic we,
  input wire logic [IW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [IW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem_q [DEPTH];
  logic [DW-1:0] rdata_q;

  assign rdata = rdata_q;

  always_ff @(posedge clock) begin
    if (ce && we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else if (ce) begin
      // Write-first, so an entry whose data lands this edge is never read stale
      rdata_q <= (we && (waddr == raddr)) ? wdata : mem_q[raddr];
    end
  end
endmodule

/* File: logic/store_load_forwarding.sv */
`timescale 1ns/1ns
`include "sfwd_defines.svh"
module store_load_forwarding
  import sfwd_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int IW = 3,
  parameter int AW = 32,
  parameter int DW = 64,
  parameter int SW = 4
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic st_alloc_valid,
  input wire logic [AW-1:0] st_alloc_addr,
  input wire logic [SW-1:0] st_alloc_size,
  output logic st_alloc_ready,
  output logic [IW-1:0] st_alloc_idx,
  input wire logic st_data_valid,
  input wire logic [IW-1:0] st_data_idx,
  input wire logic [DW-1:0] st_data,
  input wire logic st_data_fp,
  input wire logic st_retire,
  input wire logic ld_valid,
  input wire logic [AW-1:0] ld_addr,
  input wire logic [SW-1:0] ld_size,
  output logic ld_ready,
  output logic ld_done,
  output logic [DW-1:0] ld_fwd_data,
  output logic ld_blocked,
  output logic ld_split,
  output logic cache_st_valid,
  output logic [AW-1:0] cache_st_addr,
  output logic [SW-1:0] cache_st_size,
  output logic [DW-1:0] cache_st_data,
  output logic cache_st_split,
  input wire logic cache_st_ready,
  output logic cache_ld_valid,
  output logic [AW-1:0] cache_ld_addr,
  output logic [SW-1:0] cache_ld_size,
  output logic cache_ld_split,
  input wire logic cache_ld_ready
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic crosses_line(input logic [AW-1:0] a, input logic [SW-1:0] s);
    logic [`LINE_OFS_W:0] e;
    e = {1'b0, a[`LINE_OFS_W-1:0]} + (`LINE_OFS_W+1)'(s) - (`LINE_OFS_W+1)'(1);
    crosses_line = (s != '0) && e[`LINE_OFS_W];
  endfunction

  function automatic logic overlaps(input logic [AW-1:0] a0, input logic [SW-1:0] s0,
                                    input logic [AW-1:0] a1, input logic [SW-1:0] s1);
    overlaps = (a0 < a1 + AW'(s1)) && (a1 < a0 + AW'(s0));
  endfunction

  // ****************************************
  // Store buffer state
  // ****************************************
  logic [DEPTH-1:0] valid_q, valid_d, dat_q, dat_d, ret_q, ret_d, fp_q, fp_d;
  logic [AW-1:0] addr_q [DEPTH];
  logic [AW-1:0] addr_d [DEPTH];
  logic [SW-1:0] size_q [DEPTH];
  logic [SW-1:0] size_d [DEPTH];
  logic [IW-1:0] head_q, head_d, tail_q, tail_d, rptr_q, rptr_d;
  logic [IW:0] count_q, count_d;
  logic [DW-1:0] mem_rdata;
  logic [IW-1:0] mem_raddr;
  logic drain_go;
  logic hold_head;

  assign st_alloc_ready = (count_q != (IW+1)'(DEPTH));
  assign st_alloc_idx = tail_q;
  // Oldest entry drains only once retired and its data is present
  assign drain_go = valid_q[head_q] && ret_q[head_q] && dat_q[head_q] && cache_st_ready;

  // ****************************************
  // Load pipeline state
  // ****************************************
  ld_state_t state_q, state_d;
  logic [IW-1:0] cand_q, cand_d;
  logic [`WAIT_W-1:0] wait_q, wait_d;
  logic [DW-1:0] fdata_q, fdata_d;
  logic done_q, done_d;

  // Youngest older overlapping store, scanning from the oldest so later hits win
  logic hit;
  logic [IW-1:0] hit_idx;
  always_comb begin
    logic [IW-1:0] k;
    hit = 1'b0;
    hit_idx = '0;
    k = '0;
    for (int i = 0; i < DEPTH; i++) begin
      k = IW'(head_q + IW'(i));
      if (valid_q[k] && overlaps(addr_q[k], size_q[k], ld_addr, ld_size)) begin
        hit = 1'b1;
        hit_idx = k;
      end
    end
  end

  logic can_fwd;
  assign can_fwd = hit && (addr_q[hit_idx] == ld_addr)
                   && (ld_size <= size_q[hit_idx]);

  // The read port serves the forward in LD_FWD, and a candidate entry must outlive its load
  assign hold_head = (state_q == LD_FWD) || ((state_q == LD_WAIT) && (cand_q == head_q))
                     || ((state_q == LD_IDLE) && ld_valid && can_fwd && (hit_idx == head_q));

  // Buffer hits are taken only when idle and forwardable; a blocked load is rejected and replays
  assign ld_ready = hit ? ((state_q == LD_IDLE) && can_fwd) : cache_ld_ready;
  assign ld_blocked = ld_valid && (state_q == LD_IDLE) && hit && !can_fwd;
  assign ld_split = ld_valid && crosses_line(ld_addr, ld_size);
  // Unrelated loads go straight to the cache, even while a forward waits for store data
  assign cache_ld_valid = ld_valid && !hit;
  assign cache_ld_addr = ld_addr;
  assign cache_ld_size = ld_size;
  assign cache_ld_split = crosses_line(ld_addr, ld_size);
  assign ld_done = done_q;
  assign ld_fwd_data = fdata_q;
  assign mem_raddr = (state_d == LD_FWD) ? cand_d : head_d;

  always_comb begin
    state_d = state_q;
    cand_d = cand_q;
    wait_d = wait_q;
    fdata_d = fdata_q;
    done_d = 1'b0;
    case (state_q)
      LD_IDLE: begin
        if (ld_valid && can_fwd) begin
          cand_d = hit_idx;
          state_d = LD_WAIT;
        end
      end
      LD_WAIT: begin
        if (dat_q[cand_q]) begin
          wait_d = fp_q[cand_q] ? `WAIT_W'(`FP_FWD_CYCLES) : `WAIT_W'(`INT_FWD_CYCLES);
          state_d = LD_FWD;
        end
      end
      LD_FWD: begin
        if (wait_q <= `WAIT_W'(1)) begin
          fdata_d = mem_rdata;
          done_d = 1'b1;
          state_d = LD_IDLE;
        end else begin
          wait_d = wait_q - `WAIT_W'(1);
        end
      end
      default: state_d = LD_IDLE;
    endcase
  end

  // ****************************************
  // Store buffer next state
  // ****************************************
  always_comb begin
    valid_d = valid_q;
    dat_d = dat_q;
    ret_d = ret_q;
    fp_d = fp_q;
    addr_d = addr_q;
    size_d = size_q;
    head_d = head_q;
    tail_d = tail_q;
    rptr_d = rptr_q;
    count_d = count_q;
    if (st_alloc_valid && st_alloc_ready) begin
      valid_d[tail_q] = 1'b1;
      dat_d[tail_q] = 1'b0;
      ret_d[tail_q] = 1'b0;
      addr_d[tail_q] = st_alloc_addr;
      size_d[tail_q] = st_alloc_size;
      tail_d = IW'(tail_q + IW'(1));
    end
    if (st_data_valid) begin
      dat_d[st_data_idx] = 1'b1;
      fp_d[st_data_idx] = st_data_fp;
    end
    // Retirement is in order: mark the oldest not yet retired entry
    if (st_retire) begin
      ret_d[rptr_q] = 1'b1;
      rptr_d = IW'(rptr_q + IW'(1));
    end
    // A forwarding candidate is never drained while a load still reads it
    if (drain_go && !hold_head) begin
      valid_d[head_q] = 1'b0;
      head_d = IW'(head_q + IW'(1));
    end
    count_d = count_q + (IW+1)'(st_alloc_valid && st_alloc_ready) - (IW+1)'(valid_q[head_q] && !valid_d[head_q]);
  end

  assign cache_st_valid = valid_q[head_q] && ret_q[head_q] && dat_q[head_q] && !hold_head;
  assign cache_st_addr = addr_q[head_q];
  assign cache_st_size = size_q[head_q];
  assign cache_st_split = crosses_line(addr_q[head_q], size_q[head_q]);
  assign cache_st_data = mem_rdata;

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      valid_q <= '0;
      dat_q <= '0;
      ret_q <= '0;
      fp_q <= '0;
      head_q <= '0;
      tail_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
      state_q <= LD_IDLE;
      cand_q <= '0;
      wait_q <= '0;
      fdata_q <= '0;
      done_q <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        addr_q[i] <= '0;
        size_q[i] <= '0;
      end
    end else if (ce) begin
      valid_q <= valid_d;
      dat_q <= dat_d;
      ret_q <= ret_d;
      fp_q <= fp_d;
      head_q <= head_d;
      tail_q <= tail_d;
      rptr_q <= rptr_d;
      count_q <= count_d;
      state_q <= state_d;
      cand_q <= cand_d;
      wait_q <= wait_d;
      fdata_q <= fdata_d;
      done_q <= done_d;
      addr_q <= addr_d;
      size_q <= size_d;
    end
  end

  store_entry_mem #(.DEPTH(DEPTH), .DW(DW), .IW(IW)) u_mem (
    .clock(clock),
    .resetn(resetn),
    .ce(ce),
    .we(st_data_valid),
    .waddr(st_data_idx),
    .wdata(st_data),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );
endmodule

/* File: sim/sfwd_cache_model.sv */
`timescale 1ns/1ns
// ****
// Cache side
// ****
module sfwd_cache_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic slow,
  output logic st_ready,
  output logic ld_ready
);
  logic [1:0] cnt_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
  // Slow mode takes one store in four, so drains see back-pressure
  assign st_ready = !slow || (cnt_q == 2'h3);
  assign ld_ready = 1'b1;
endmodule

/* File: sim/store_load_forwarding_chk.sv */
`timescale 1ns/1ns
// ****
// Checker
// ****
module sfwd_chk (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic st_retire,
  input wire logic ld_valid,
  input wire logic [31:0] ld_addr,
  input wire logic [3:0] ld_size,
  input wire logic ld_ready,
  input wire logic ld_done,
  input wire logic ld_blocked,
  input wire logic ld_split,
  input wire logic cache_st_valid,
  input wire logic [31:0] cache_st_addr,
  input wire logic [3:0] cache_st_size,
  input wire logic cache_st_split,
  input wire logic cache_st_ready,
  input wire logic cache_ld_valid,
  input wire logic [31:0] cache_ld_addr,
  input wire logic [3:0] cache_ld_size,
  input wire logic cache_ld_split,
  input wire logic cache_ld_ready
);
  logic [3:0] ret_q;
  logic [3:0] ret_d;
  always_comb begin
    ret_d = ret_q + 4'(st_retire) - 4'(cache_st_valid && cache_st_ready);
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ret_q <= 4'h0;
    end else if (ce) begin
      ret_q <= ret_d;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  ld_split_a: assert property (ld_valid |-> ld_split == (ld_addr[5:0] + ld_size > 7'h40)) else $error("ld split");
  cld_split_a: assert property (cache_ld_valid |->
    cache_ld_split == (cache_ld_addr[5:0] + cache_ld_size > 7'h40)) else $error("cache ld split");
  cst_split_a: assert property (cache_st_valid |->
    cache_st_split == (cache_st_addr[5:0] + cache_st_size > 7'h40)) else $error("cache st split");
  retired_only_a: assert property (cache_st_valid |-> ret_q != 4'h0) else $error("unretired drain");
  cache_issue_a: assert property (cache_ld_valid |-> ld_valid && (ld_ready == cache_ld_ready)
    && cache_ld_addr == ld_addr && cache_ld_size == ld_size) else $error("bad cache load");
  blocked_refuse_a: assert property (ld_blocked |-> !ld_ready) else $error("blocked taken");
  fwd_done_a: assert property (ld_valid && ld_ready && !cache_ld_valid && ce |=>
    !ld_done [*2] ##[1:60] ld_done) else $error("fwd latency");
  done_pulse_a: assert property (ld_done |=> !ld_done) else $error("done width");
  fwd_c: cover property (ld_done);
  blk_c: cover property (ld_blocked);
  drain_c: cover property (cache_st_valid && cache_st_ready);
endmodule
bind store_load_forwarding sfwd_chk chk_u (.*);

/* File: sim/test_store_load_forwarding.sv */
`timescale 1ns/1ns
// ****
// Bench
// ****
module test_store_load_forwarding;
  logic clock = 1'b0, resetn = 1'b0, ce = 1'b1, slow = 1'b0;
  logic st_alloc_valid = 1'b0, st_data_valid = 1'b0, st_data_fp = 1'b0, st_retire = 1'b0, ld_valid = 1'b0;
  logic [31:0] st_alloc_addr = 32'h0, ld_addr = 32'h0, cache_st_addr, cache_ld_addr;
  logic [3:0] st_alloc_size = 4'h0, ld_size = 4'h0, cache_st_size, cache_ld_size;
  logic [2:0] st_data_idx = 3'h0, st_alloc_idx, ix;
  logic [63:0] st_data = 64'h0, ld_fwd_data, cache_st_data, got;
  logic st_alloc_ready, ld_ready, ld_done, ld_blocked, ld_split, cache_st_valid, cache_st_split;
  logic cache_st_ready, cache_ld_valid, cache_ld_split, cache_ld_ready, fw, blk, cl, sp, cs;
  logic [31:0] at [7] = '{32'h100, 32'h200, 32'h300, 32'h400, 32'h500, 32'h500, 32'h3C};
  int error_cnt = 0, n_tests = 0, lat;
  store_load_forwarding dut_u (.*);
  sfwd_cache_model cache_u (.clock(clock), .resetn(resetn), .slow(slow), .st_ready(cache_st_ready),
    .ld_ready(cache_ld_ready));
  function automatic logic [63:0] dv(input int n);
    return 64'h0101010101010101 * n;
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic put(input logic [2:0] i, input int n, input logic fp);
    @(negedge clock);
    st_data_valid = 1'b1;
    st_data_idx = i;
    st_data = dv(n);
    st_data_fp = fp;
    @(negedge clock);
    st_data_valid = 1'b0;
  endtask
  task automatic st(input logic [31:0] a, input logic [3:0] s, input int n, input logic fp, input logic dat);
    @(negedge clock);
    st_alloc_valid = 1'b1;
    st_alloc_addr = a;
    st_alloc_size = s;
    ix = st_alloc_idx;
    chk(st_alloc_ready, 1'b1);
    @(negedge clock);
    st_alloc_valid = 1'b0;
    if (dat) put(ix, n, fp);
  endtask
  // Forward latency is counted in falling edges after the load is taken
  task automatic load(input logic [31:0] a, input logic [3:0] s);
    @(negedge clock);
    ld_valid = 1'b1;
    ld_addr = a;
    ld_size = s;
    #1;
    {blk, cl, sp, cs} = {ld_blocked, cache_ld_valid, ld_split, cache_ld_split};
    fw = ld_ready && !cache_ld_valid;
    @(negedge clock);
    ld_valid = 1'b0;
    lat = 1;
    while (fw && ld_done !== 1'b1 && lat < 80) begin
      @(negedge clock);
      lat++;
    end
    got = ld_fwd_data;
    if (fw && ld_done !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end
  endtask
  task automatic t_fwd;
    st(at[0], 4'h8, 1, 1'b0, 1'b1);
    load(at[0], 4'h8);
    chk(fw, 1'b1);
    chk(lat, 3);
    chk(got, dv(1));
    st(at[1], 4'h8, 2, 1'b1, 1'b1);
    load(at[1], 4'h8);
    chk(lat, 6);
    chk(got, dv(2));
    $display("forward latency test done");
  endtask
  task automatic t_rules;
    load(32'h101, 4'h1);
    chk(blk, 1'b1);
    st(at[2], 4'h4, 3, 1'b0, 1'b1);
    load(at[2], 4'h8);
    chk(blk, 1'b1);
    load(32'h1000, 4'h4);
    chk(cl, 1'b1);
    load(at[2], 4'h2);
    chk(fw, 1'b1);
    load(32'h7E, 4'h4);
    chk({sp, cs}, 2'b11);
    load(32'h7C, 4'h4);
    chk({sp, cs}, 2'b00);
    $display("match rules test done");
  endtask
  task automatic t_late;
    st(at[3], 4'h8, 4, 1'b0, 1'b0);
    fork
      load(at[3], 4'h8);
      begin
        repeat (3) @(negedge clock);
        ld_valid = 1'b1;
        ld_addr = 32'h2000;
        #1;
        chk({cache_ld_valid, ld_ready}, 2'b11);
        @(negedge clock);
        ld_valid = 1'b0;
        put(ix, 4, 1'b0);
      end
    join
    chk(got, dv(4));
    chk(lat > 5, 1'b1);
    st(at[4], 4'h8, 5, 1'b0, 1'b1);
    st(at[5], 4'h8, 6, 1'b0, 1'b1);
    load(at[5], 4'h8);
    chk(got, dv(6));
    st(at[6], 4'h8, 7, 1'b0, 1'b1);
    $display("late data test done");
  endtask
  task automatic t_drain;
    slow = 1'b1;
    chk(cache_st_valid, 1'b0);
    for (int k = 0; k < 7; k++) begin
      @(negedge clock);
      st_retire = 1'b1;
      @(negedge clock);
      st_retire = 1'b0;
      lat = 0;
      while (!(cache_st_valid && cache_st_ready) && lat < 20) begin
        @(negedge clock);
        lat++;
      end
      if (!(cache_st_valid && cache_st_ready)) begin
        error_cnt++;
        end_of_test();
      end
      chk(cache_st_valid && cache_st_ready, 1'b1);
      chk(cache_st_size, (k == 2) ? 4'h4 : 4'h8);
      chk({cache_st_addr, cache_st_split}, {at[k], k == 6});
      chk(cache_st_data, dv(k + 1));
    end
    $display("drain test done");
  endtask
  initial begin
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    t_fwd();
    t_rules();
    t_late();
    t_drain();
    end_of_test();
  end
endmodule
